// ===== rtl/dcp_pkg.sv
// Purpose: shared constants for both ends of the debug channel apb slave port
// Assumes: apb4 signalling, 32-bit data, 12-bit byte address
// Notes: offsets are byte addresses inside the 4 KB window
package dcp_pkg;
    // bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register offsets inside the window
    localparam logic [11:0] STATUS_OFS = 12'h000;
    localparam logic [11:0] DATA_OFS = 12'h004;
    // low address bits that must be zero for a word access
    localparam logic [1:0] ALIGN_ZERO = 2'h0;
    // status register field positions
    localparam int STAT_PEN_BIT = 0;
    localparam int STAT_RRDIS_BIT = 1;
    // fixed values
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    // wait states the slave inserts before ready
    localparam int WAIT_CYCLES = 1;
    localparam int CNT_W = 4;
    localparam logic [3:0] WAIT_LOAD = 4'(WAIT_CYCLES);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage : dcp_pkg

// ===== rtl/dcp_apb_if.sv
// Purpose: apb4 link between the debug-side master and the port slave
// Assumes: both ends on the same clock
// Notes: wake-up request travels beside the apb signals
`timescale 1ns/100ps
interface dcp_apb_if;
    logic [11:0] paddr;    // byte address
    logic pwrite;          // high write, low read
    logic psel;            // slave select
    logic penable;         // access phase
    logic [31:0] pwdata;   // write data
    logic [31:0] prdata;   // read data
    logic pready;          // transfer done
    logic pslverr;         // transfer aborted with error
    logic pwakeup;         // glitch-free wake-up request
    // the port end
    modport dev (
        input paddr, pwrite, psel, penable, pwdata, pwakeup,
        output prdata, pready, pslverr
    );
    // the debug-side master end
    modport mst (
        output paddr, pwrite, psel, penable, pwdata, pwakeup,
        input prdata, pready, pslverr
    );
endinterface : dcp_apb_if

// ===== rtl/dcp_apb_slave.sv
// Purpose: apb4 slave end of the debug channel port with status and data words
// Assumes: static configuration inputs, master keeps the wake-up protocol
// Notes: while clamped the slave holds ready, read data and error at zero
// Function
// - master raises wake-up before a new transfer
// - wake-up stays high while select is high
// - master drives wake-up free of glitches
// - activity output follows wake-up, not select
// - remote reboot disable shown read-only
// - static port enable shown in status
// - write high means write, low read
// - enable follows select by one cycle
// - write data accepted, zero when clamped
// - read data driven, zero when clamped
// - ready held low for wait states
// - slave error flags an aborted transfer
`timescale 1ns/100ps
module dcp_apb_slave
    import dcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    dcp_apb_if.dev apb,
    input wire logic remote_reboot_disable_cfg,
    input wire logic port_enable_cfg,
    input wire logic clamp_en,
    output logic clock_channel_activity_out,
    output logic [31:0] data_word
);

    // transfer sequencing states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } dcp_slv_state_e;

    dcp_slv_state_e state_r;        // current state
    dcp_slv_state_e state_nxt;      // next state
    logic [3:0] wait_cnt_r;         // wait states still to insert
    logic [31:0] data_r;            // writable data word
    logic [31:0] prdata_r;          // registered read data
    logic pready_r;                 // registered ready
    logic pslverr_r;                // registered error
    logic activity_r;               // registered activity output
    logic [31:0] wdata_eff;         // write data after clamp
    logic [31:0] status_word;       // live status register value
    logic access;                   // access phase seen this cycle
    logic hit_status;               // address selects status
    logic hit_data;                 // address selects data
    logic bad_access;               // unmapped, unaligned or read-only write
    logic [31:0] rd_mux;            // read data before the register

    // the clamp forces incoming write data to zero
    assign wdata_eff = clamp_en ? ZERO_WORD : apb.pwdata;

    // status bits come straight from the configuration pins, no write path exists
    // the pins are static, so no synchroniser is spent on them
    always_comb begin
        status_word = ZERO_WORD;
        status_word[STAT_PEN_BIT] = port_enable_cfg;
        status_word[STAT_RRDIS_BIT] = remote_reboot_disable_cfg;
    end

    // access phase: select and enable both high, enable trails select by one cycle
    assign access = apb.psel && apb.penable;

    // address decode over the 4 KB window, word aligned only
    always_comb begin
        hit_status = 1'b0;
        hit_data = 1'b0;
        bad_access = 1'b0;
        rd_mux = ZERO_WORD;
        // alignment goes first so an unaligned address near a mapped word is refused
        if (apb.paddr[1:0] != ALIGN_ZERO) begin
            // unaligned address is refused
            bad_access = 1'b1;
        end else if (apb.paddr == STATUS_OFS) begin
            hit_status = 1'b1;
            rd_mux = status_word;
            // status is read-only, so a write is an error
            bad_access = apb.pwrite;
        end else if (apb.paddr == DATA_OFS) begin
            hit_data = 1'b1;
            rd_mux = data_r;
        end else begin
            // nothing mapped here
            bad_access = 1'b1;
        end
    end

    // next-state logic for one transfer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // a clamped port never starts answering
                if (access && !clamp_en) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // a clamp mid-wait drops the answer; access still stands, so it restarts
                if (clamp_en) begin
                    state_nxt = ST_IDLE;
                end else if (wait_cnt_r <= CNT_ONE) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // ready was high for one edge, the master ends the transfer
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state register, sampled on the rising edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // wait-state counter, loaded as the access phase starts
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt_r <= CNT_ZERO;
        end else if (state_r == ST_IDLE && access) begin
            wait_cnt_r <= WAIT_LOAD;
        end else if (state_r == ST_WAIT && wait_cnt_r != CNT_ZERO) begin
            // stops at zero so the count never wraps into a long wait
            wait_cnt_r <= wait_cnt_r - CNT_ONE;
        end
    end

    // ready stays low through the wait states and while clamped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready_r <= 1'b0;
        end else if (clamp_en) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= (state_nxt == ST_DONE);
        end
    end

    // error answer, valid only with ready
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pslverr_r <= 1'b0;
        end else if (!clamp_en && state_nxt == ST_DONE) begin
            pslverr_r <= bad_access;
        end else begin
            // error is a pulse, it never outlives the ready cycle
            pslverr_r <= 1'b0;
        end
    end

    // read data only on a good read, zero otherwise so nothing leaks
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= ZERO_WORD;
        end else if (clamp_en) begin
            prdata_r <= ZERO_WORD;
        end else if (state_nxt == ST_DONE && !apb.pwrite && !bad_access) begin
            prdata_r <= rd_mux;
        end else begin
            // zero between answers so nothing stale sits on the bus
            prdata_r <= ZERO_WORD;
        end
    end

    // data word write, committed together with the ready answer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_r <= DATA_RST;
        end else if (!clamp_en && state_nxt == ST_DONE && apb.pwrite && hit_data) begin
            // committing with ready means a clamp mid-wait leaves the word untouched
            data_r <= wdata_eff;
        end
    end

    // activity from the glitch-free wake-up, select may glitch and is not used
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            activity_r <= 1'b0;
        end else begin
            // one flop is enough: wake-up already comes clean from a flop on this clock
            activity_r <= apb.pwakeup;
        end
    end

    // all outputs straight from flip-flops
    // no logic between these flops and the pins, so the master sees clean levels
    assign apb.prdata = prdata_r;
    assign apb.pready = pready_r;
    assign apb.pslverr = pslverr_r;
    assign clock_channel_activity_out = activity_r;
    assign data_word = data_r;

endmodule : dcp_apb_slave

// ===== rtl/dcp_apb_master.sv
// Purpose: debug-side apb4 master end driving the port slave
// Assumes: one request at a time from the user side
// Notes: wake-up rises one cycle before select and drops after the transfer
`timescale 1ns/100ps
module dcp_apb_master
    import dcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    dcp_apb_if.mst apb,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [11:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    output logic resp_err
);

    // master sequencing states
    typedef enum logic [1:0] {
        MS_IDLE,
        MS_WAKE,
        MS_SETUP,
        MS_ACCESS
    } dcp_mst_state_e;

    dcp_mst_state_e state_r;   // current state
    logic [11:0] paddr_r;      // held address
    logic pwrite_r;            // held direction
    logic [31:0] pwdata_r;     // held write data
    logic psel_r;              // select
    logic penable_r;           // enable
    logic wake_r;              // wake-up request, a flop so it cannot glitch
    logic resp_valid_r;        // response pulse
    logic [31:0] resp_rdata_r; // captured read data
    logic resp_err_r;          // captured error

    // one process per transfer: wake, setup, access
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= MS_IDLE;
            paddr_r <= 12'h000;
            pwrite_r <= 1'b0;
            pwdata_r <= ZERO_WORD;
            psel_r <= 1'b0;
            penable_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            case (state_r)
                MS_IDLE: begin
                    if (req_valid) begin
                        // wake-up goes first so the clock is requested early
                        wake_r <= 1'b1;
                        paddr_r <= req_addr;
                        pwrite_r <= req_write;
                        pwdata_r <= req_write ? req_wdata : ZERO_WORD;
                        state_r <= MS_WAKE;
                    end
                end
                MS_WAKE: begin
                    psel_r <= 1'b1;
                    state_r <= MS_SETUP;
                end
                MS_SETUP: begin
                    penable_r <= 1'b1;
                    state_r <= MS_ACCESS;
                end
                MS_ACCESS: begin
                    if (apb.pready) begin
                        // wake-up drops with select, never before it
                        psel_r <= 1'b0;
                        penable_r <= 1'b0;
                        wake_r <= 1'b0;
                        state_r <= MS_IDLE;
                    end
                end
                default: begin
                    state_r <= MS_IDLE;
                end
            endcase
        end
    end

    // response capture on the ready edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            resp_valid_r <= 1'b0;
            resp_rdata_r <= ZERO_WORD;
            resp_err_r <= 1'b0;
        end else begin
            resp_valid_r <= (state_r == MS_ACCESS) && apb.pready;
            if (state_r == MS_ACCESS && apb.pready) begin
                resp_rdata_r <= apb.prdata;
                resp_err_r <= apb.pslverr;
            end
        end
    end

    // outputs from flops
    assign apb.paddr = paddr_r;
    assign apb.pwrite = pwrite_r;
    assign apb.pwdata = pwdata_r;
    assign apb.psel = psel_r;
    assign apb.penable = penable_r;
    assign apb.pwakeup = wake_r;
    assign resp_valid = resp_valid_r;
    assign resp_rdata = resp_rdata_r;
    assign resp_err = resp_err_r;
    // idle flag is a decode of the state flop only
    assign req_ready = (state_r == MS_IDLE);

endmodule : dcp_apb_master

// ===== bench/dcp_apb_monitor.sv
// Purpose: concurrent checks on the link between the two debug channel port ends
// Assumes: one clock domain, master and slave both design code
// Notes: instantiated beside the interface, watches wires only
`timescale 1ns/100ps
module dcp_apb_monitor (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic pwrite,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwakeup,
    input wire logic clamp_en,
    input wire logic clock_channel_activity_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // first access edge of an unclamped transfer
    sequence s_taken;
        $rose(penable) && psel && !clamp_en;
    endsequence
    // one wait state, then a single ready pulse
    sequence s_answer;
        !pready ##1 pready ##1 !pready;
    endsequence
    property p_wait_state;
        s_taken |=> s_answer;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("ready timing wrong");
    // activity must follow the clean request, never the select
    property p_act_follows_wake;
        1'b1 |=> (clock_channel_activity_out == $past(pwakeup));
    endproperty
    a_act_follows_wake: assert property (p_act_follows_wake) else $error("activity bad");
    property p_wake_before_sel;
        $rose(psel) |-> $past(pwakeup);
    endproperty
    a_wake_before_sel: assert property (p_wake_before_sel) else $error("wake late");
    property p_wake_during_sel;
        psel |-> pwakeup;
    endproperty
    a_wake_during_sel: assert property (p_wake_during_sel) else $error("wake dropped");
    property p_enable_after_sel;
        $rose(psel) |-> !penable ##1 penable;
    endproperty
    a_enable_after_sel: assert property (p_enable_after_sel) else $error("enable late");
    // direction and address must not move inside a transfer
    property p_dir_stable;
        psel && $past(psel) |-> $stable(pwrite) && $stable(paddr);
    endproperty
    a_dir_stable: assert property (p_dir_stable) else $error("direction moved");
    property p_err_with_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
    property p_rdata_zero;
        prdata != 32'h00000000 |-> pready && !pwrite && !pslverr;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data not zero");
    // a clamped port answers nothing at all
    property p_clamp_quiet;
        clamp_en && $past(clamp_en) |-> !pready && !pslverr && prdata == 32'h00000000;
    endproperty
    a_clamp_quiet: assert property (p_clamp_quiet) else $error("clamp leaked");
    // a clean wake-up never shows as a one-sample pulse
    property p_wake_no_pulse;
        $rose(pwakeup) |=> pwakeup;
    endproperty
    a_wake_no_pulse: assert property (p_wake_no_pulse) else $error("wake pulse");
endmodule : dcp_apb_monitor

// ===== bench/debug_channel_apb_slave_port_tb_top.sv
// Purpose: self-checking bench for master and slave ends joined back to back
// Assumes: responses come back in request order
// Notes: expectations are queued by the driver and matched by a watcher
`timescale 1ns/100ps
module debug_channel_apb_slave_port_tb_top;
    import dcp_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic remote_reboot_disable_cfg, port_enable_cfg, clamp_en;
    logic req_valid, req_write, req_ready, resp_valid, resp_err, clock_channel_activity_out;
    logic [11:0] req_addr;
    logic [31:0] req_wdata, resp_rdata, data_word, wd;
    logic [33:0] exp_q[$]; // {data checked, error, read data}
    int err_count = 0;
    int checks = 0;
    int resp_cnt = 0;
    int cyc = 0;
    int n;
    dcp_apb_if u_dcp_apb_if();
    dcp_apb_master u_dcp_apb_master (.sys_clk(sys_clk), .resetn(resetn), .apb(u_dcp_apb_if),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .resp_err(resp_err));
    dcp_apb_slave u_dcp_apb_slave (.sys_clk(sys_clk), .resetn(resetn), .apb(u_dcp_apb_if),
        .remote_reboot_disable_cfg(remote_reboot_disable_cfg),
        .port_enable_cfg(port_enable_cfg), .clamp_en(clamp_en),
        .clock_channel_activity_out(clock_channel_activity_out), .data_word(data_word));
    dcp_apb_monitor u_dcp_apb_monitor (.sys_clk(sys_clk), .resetn(resetn),
        .paddr(u_dcp_apb_if.paddr), .pwrite(u_dcp_apb_if.pwrite), .psel(u_dcp_apb_if.psel),
        .penable(u_dcp_apb_if.penable), .prdata(u_dcp_apb_if.prdata),
        .pready(u_dcp_apb_if.pready), .pslverr(u_dcp_apb_if.pslverr),
        .pwakeup(u_dcp_apb_if.pwakeup), .clamp_en(clamp_en),
        .clock_channel_activity_out(clock_channel_activity_out));
    // 40 ns clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word
    task cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flag
    // one request through the master, returns once its response was matched
    task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdat,
              input logic e_err, input logic [31:0] e_rd);
        int start;
        start = resp_cnt;
        exp_q.push_back({~wr, e_err, e_rd}); // write data answer is not compared
        req_valid = 1'b1;
        req_write = wr;
        req_addr = addr;
        req_wdata = wdat;
        @(posedge sys_clk);
        while (req_ready !== 1'b1) @(posedge sys_clk);
        #1 req_valid = 1'b0;
        while (resp_cnt == start) @(posedge sys_clk);
        #1;
    endtask : xfer
    // watcher: matches each response against the oldest note
    always @(posedge sys_clk) begin : watch
        logic [33:0] e;
        if (resetn === 1'b1 && resp_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
            resp_cnt++;
            cmp_flag(resp_err, e[32]);
            if (e[33]) cmp_word(resp_rdata, e[31:0]);
        end
    end
    // hang guard, the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        {req_valid, req_write, req_addr, req_wdata} = '0;
        {remote_reboot_disable_cfg, port_enable_cfg, clamp_en} = 3'h0;
        void'($urandom(32'h7a12));
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1'b1;
        // every configuration pair shows up in the status word
        for (int i = 0; i < 4; i++) begin
            {remote_reboot_disable_cfg, port_enable_cfg} = 2'(i);
            xfer(1'b0, STATUS_OFS, ZERO_WORD, 1'b0, 32'(i));
        end
        // status is read-only: refused, and unchanged afterwards
        xfer(1'b1, STATUS_OFS, 32'hFFFFFFFF, 1'b1, ZERO_WORD);
        xfer(1'b0, STATUS_OFS, ZERO_WORD, 1'b0, 32'h00000003);
        // back-to-back write and read of random words
        for (int k = 0; k < 3; k++) begin
            wd = $urandom;
            xfer(1'b1, DATA_OFS, wd, 1'b0, ZERO_WORD);
            cmp_word(data_word, wd);
            xfer(1'b0, DATA_OFS, ZERO_WORD, 1'b0, wd);
        end
        // aborted transfers: unaligned, unmapped, data left untouched
        xfer(1'b0, 12'h005, ZERO_WORD, 1'b1, ZERO_WORD);
        xfer(1'b1, 12'h006, $urandom, 1'b1, ZERO_WORD);
        xfer(1'b0, 12'hFFC, ZERO_WORD, 1'b1, ZERO_WORD);
        xfer(1'b0, DATA_OFS, ZERO_WORD, 1'b0, wd);
        // clamped port hangs the transfer until the clamp lifts
        clamp_en = 1'b1;
        wd = $urandom;
        n = resp_cnt;
        fork
            xfer(1'b1, DATA_OFS, wd, 1'b0, ZERO_WORD);
            begin
                repeat (12) @(posedge sys_clk);
                cmp_word(32'(resp_cnt - n), 32'h00000000);
                #1 clamp_en = 1'b0;
            end
        join
        cmp_word(data_word, wd);
        close_out;
    end
endmodule : debug_channel_apb_slave_port_tb_top
